// ===== src/tx_seq_pkg.sv
// Constants, event codes and state encoding for the transmit event sequencer
package tx_seq_pkg;

   // -------------------------------------------------------------
   // Timebase
   // -------------------------------------------------------------
   localparam real SAMPLE_PERIOD_US = 20.833;
   localparam real CLK_PERIOD_NS = 5.0;
   // Truncated, so the tick runs a hair fast rather than slow
   localparam int SAMPLE_DIV = $rtoi(SAMPLE_PERIOD_US * 1000.0 / CLK_PERIOD_NS);

   // -------------------------------------------------------------
   // Table geometry
   // -------------------------------------------------------------
   localparam int NUM_EVENTS = 14;
   localparam logic [3:0] FIRST_IDX = 4'h0;
   localparam logic [3:0] FINAL_FIRST = 4'h8;
   localparam logic [3:0] LAST_IDX = 4'hd;
   localparam logic [3:0] WR_PTR_MAX = 4'hf;

   // -------------------------------------------------------------
   // Fixed delays in sample ticks
   // -------------------------------------------------------------
   localparam logic [15:0] LEAD_SAMPLES = 16'h0004;
   localparam logic signed [19:0] MOD_END_EXTRA = 20'sh0002e;
   localparam logic [23:0] MOD_END_EXTRA_U = 24'h00002e;
   localparam logic [5:0] AIS_SPB = 6'h05;
   localparam logic [5:0] FSK_SPB = 6'h28;

   // -------------------------------------------------------------
   // Event codes
   // -------------------------------------------------------------
   localparam logic [3:0] EV_RADIO_ON = 4'h1;
   localparam logic [3:0] EV_TX_ON = 4'h2;
   localparam logic [3:0] EV_AMPLIFIER_ON = 4'h3;
   localparam logic [3:0] EV_RAMP_UP = 4'h4;
   localparam logic [3:0] EV_SENSE_WINDOW_OPEN = 4'h5;
   localparam logic [3:0] EV_SENSE_WINDOW_CLOSE = 4'h6;
   localparam logic [3:0] EV_MODULATION_BEGIN = 4'h7;
   localparam logic [3:0] EV_MODULATION_FINISH = 4'h8;
   localparam logic [3:0] EV_RAMP_DOWN = 4'h9;
   localparam logic [3:0] EV_AMPLIFIER_OFF = 4'ha;
   localparam logic [3:0] EV_TX_OFF = 4'hb;
   localparam logic [3:0] EV_RADIO_OFF = 4'hc;
   localparam logic [3:0] EV_NO_ACTION = 4'hd;
   localparam logic [3:0] EV_CHAIN_START = 4'he;
   localparam logic [3:0] EV_CHAIN_END = 4'hf;

   // -------------------------------------------------------------
   // Enable pin positions in the idle state word
   // -------------------------------------------------------------
   localparam int PIN_RF = 0;
   localparam int PIN_RX_LO = 1;
   localparam int PIN_RX_HI = 3;
   localparam int PIN_TX = 4;
   localparam int PIN_AMP = 5;

   // Gray codes along idle, pending, lead, run, feed
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_PENDING = 3'b001,
      ST_LEAD = 3'b011,
      ST_RUN = 3'b010,
      ST_FEED = 3'b110
   } seq_state_type;

endpackage : tx_seq_pkg

// ===== src/sample_tick_gen.sv
// Divider that makes the one-cycle sample tick enable
`timescale 1ns/1ps
module sample_tick_gen
#(
   parameter int DIV = tx_seq_pkg::SAMPLE_DIV
)
(
   input wire logic clk,
   input wire logic nrst,
   output logic tick
);

   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] TOP = CW'(DIV - 1);

   logic [CW-1:0] div_q;
   logic [CW-1:0] div_d;
   wire wrap = (div_q == TOP);

   // Free running count; tick marks the wrap
   assign div_d = wrap ? '0 : div_q + CW'(1);
   assign tick = wrap;

   always_ff @(posedge clk)
   begin
      if (!nrst)
         div_q <= '0;
      else
         div_q <= div_d;
   end

endmodule : sample_tick_gen

// ===== src/tx_event_sequencer.sv
// Transmit event sequencer: table load, timed events, enable outputs
//
// Contract
// - End of modulation gets 46 extra samples
// - Each event timed from the previous event, except the first of the final group
// - First entry: start sample, pin idle state
// - Four sample lead before first event delay
// - Amplifier on asserts amp, negates receive lines
// - Amplifier off negates amp, reasserts receive lines
// - Codes 5 and 6 open/close sense window
// - Code 14 marks loop, 15 loops if data
// - Modulation span is bits times rate plus 46
// - Codes 4 and 9 trigger ramp up/down
// - Code 7 starts bits, 8 ends modulation
// - Code 1 asserts radio, 12 negates
// - Code 2 asserts transmitter, 11 negates
// - Sense window only before first chained message
// - Ramp-down before finish fires ahead of it
// - Final six events timed from last bit
// - All timing in sample ticks: one fifth of an AIS bit, one fortieth of an FSK bit
`timescale 1ns/1ps
module tx_event_sequencer
#(
   parameter int SAMPLE_DIV = tx_seq_pkg::SAMPLE_DIV
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic seq_load,
   input wire logic seq_poke,
   input wire logic seq_setup,
   input wire logic [15:0] command_param_zero,
   input wire logic [15:0] command_param_one,
   input wire logic tx_start,
   input wire logic tx_clear,
   input wire logic slot_match,
   input wire logic [15:0] sample_count,
   input wire logic [15:0] bit_total,
   input wire logic fsk_mode,
   input wire logic sense_enable,
   input wire logic fifo_has_data,
   output logic rf_enable_out,
   output logic tx_enable_out,
   output logic amp_enable_out,
   output logic [2:0] rx_control_outs,
   output logic ramp_up_pulse,
   output logic ramp_down_pulse,
   output logic sense_window,
   output logic modulation_active,
   output logic bit_strobe,
   output logic mod_finish_pulse,
   output logic tx_busy,
   output logic tx_done_pulse,
   output logic table_ready
);

   // ----------------------------------------------------------------
   // Table storage and load pointer
   // ----------------------------------------------------------------
   logic [3:0] ev_code_q [0:tx_seq_pkg::NUM_EVENTS-1];
   logic [14:0] ev_delay_q [0:tx_seq_pkg::NUM_EVENTS-1];
   logic [15:0] start_sample_q;
   logic [5:0] idle_state_q;
   logic [3:0] wr_ptr_q;
   logic ready_q;

   // ----------------------------------------------------------------
   // Sequencer state
   // ----------------------------------------------------------------
   tx_seq_pkg::seq_state_type state_q;
   logic [3:0] idx_q;
   logic [3:0] chain_idx_q;
   logic [15:0] cnt_q;
   logic first_msg_q;
   logic done_q;
   logic [5:0] enab_q;
   logic ramp_up_q;
   logic ramp_down_q;
   logic sense_q;
   logic mod_q;
   logic [15:0] bits_q;
   logic fsk_q;
   logic [15:0] feed_left_q;
   logic [5:0] phase_q;
   logic strobe_q;
   logic finish_q;
   logic [23:0] mod_ticks_q;
   logic tick;

   // Short pin positions keep the decode lines within the line width
   localparam int PRF = tx_seq_pkg::PIN_RF;
   localparam int PTX = tx_seq_pkg::PIN_TX;
   localparam int PAMP = tx_seq_pkg::PIN_AMP;
   localparam int PRXL = tx_seq_pkg::PIN_RX_LO;
   localparam int PRXH = tx_seq_pkg::PIN_RX_HI;

   // Sample timebase
   sample_tick_gen #(.DIV(SAMPLE_DIV)) u_tick
   (
      .clk(clk),
      .nrst(nrst),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire [3:0] code_now = ev_code_q[idx_q];
   wire cnt_last = (cnt_q == 16'h0001);
   wire fire = (state_q == tx_seq_pkg::ST_RUN) && tick && cnt_last;
   wire chain_jump = fire && (code_now == tx_seq_pkg::EV_CHAIN_END)
      && fifo_has_data;
   wire [3:0] nxt_idx = chain_jump ? chain_idx_q + 4'h1 : idx_q + 4'h1;
   wire [15:0] next_delay = 16'(ev_delay_q[nxt_idx]);
   wire seq_begin = (state_q == tx_seq_pkg::ST_IDLE) && tx_start && ready_q;
   // Equality only: a counter that jumps over the start leaves us pending
   wire start_hit = (state_q == tx_seq_pkg::ST_PENDING) && tick
      && slot_match && (sample_count == start_sample_q);
   wire [5:0] spb = fsk_q ? tx_seq_pkg::FSK_SPB : tx_seq_pkg::AIS_SPB;
   wire poke_evt = seq_poke && (wr_ptr_q != '0)
      && (wr_ptr_q <= 4'(tx_seq_pkg::NUM_EVENTS));

   // Offset of the finish point inside the final group
   logic [18:0] end_off;
   always_comb
   begin
      logic found;
      found = 1'b0;
      end_off = '0;
      for (int k = tx_seq_pkg::FINAL_FIRST; k < tx_seq_pkg::NUM_EVENTS; k++)
      begin
         if (!found)
            end_off = end_off + 19'(ev_delay_q[k]);
         if (ev_code_q[k] == tx_seq_pkg::EV_MODULATION_FINISH)
            found = 1'b1;
      end
   end

   // Final group is timed from the last bit; events ahead of the finish
   // point land early. A negative result is clamped to one tick.
   wire signed [19:0] tail_raw = tx_seq_pkg::MOD_END_EXTRA
      + 20'(ev_delay_q[tx_seq_pkg::FINAL_FIRST]) - 20'(end_off);
   wire tail_ok = (tail_raw > 20'sh00000) && (tail_raw < 20'sh10000);
   wire [15:0] tail_cnt = tail_ok ? tail_raw[15:0] : 16'h0001;

   // ----------------------------------------------------------------
   // Table load
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         wr_ptr_q <= '0;
         ready_q <= 1'b0;
         start_sample_q <= '0;
         idle_state_q <= '0;
      end
      else if (seq_load)
      begin
         wr_ptr_q <= '0;
         ready_q <= 1'b0;
      end
      else
      begin
         if (seq_poke && wr_ptr_q == '0)
         begin
            start_sample_q <= command_param_zero;
            idle_state_q <= command_param_one[5:0];
         end
         if (seq_poke && wr_ptr_q != tx_seq_pkg::WR_PTR_MAX)
            wr_ptr_q <= wr_ptr_q + 4'h1;
         if (seq_setup)
            ready_q <= 1'b1;
      end
   end

   // One storage slot per table entry
   for (genvar i = 0; i < tx_seq_pkg::NUM_EVENTS; i++)
   begin : g_entry
      always_ff @(posedge clk)
      begin
         if (!nrst)
         begin
            ev_code_q[i] <= tx_seq_pkg::EV_NO_ACTION;
            ev_delay_q[i] <= 15'h0001;
         end
         else if (poke_evt && wr_ptr_q == 4'(i + 1))
         begin
            ev_code_q[i] <= command_param_zero[3:0];
            ev_delay_q[i] <= command_param_one[14:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Event walker: one event at a time, relative delays
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst || tx_clear)
      begin
         state_q <= tx_seq_pkg::ST_IDLE;
         idx_q <= '0;
         cnt_q <= '0;
         chain_idx_q <= '0;
         first_msg_q <= 1'b1;
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         unique case (state_q)
            tx_seq_pkg::ST_IDLE:
               if (seq_begin)
               begin
                  state_q <= tx_seq_pkg::ST_PENDING;
                  first_msg_q <= 1'b1;
               end
            tx_seq_pkg::ST_PENDING:
               if (start_hit)
               begin
                  state_q <= tx_seq_pkg::ST_LEAD;
                  cnt_q <= tx_seq_pkg::LEAD_SAMPLES;
               end
            tx_seq_pkg::ST_LEAD:
               if (tick && cnt_last)
               begin
                  state_q <= tx_seq_pkg::ST_RUN;
                  idx_q <= tx_seq_pkg::FIRST_IDX;
                  cnt_q <= 16'(ev_delay_q[0]);
               end
               else if (tick)
                  cnt_q <= cnt_q - 16'h0001;
            tx_seq_pkg::ST_RUN:
               if (fire)
               begin
                  if (chain_jump)
                     first_msg_q <= 1'b0;
                  if (code_now == tx_seq_pkg::EV_CHAIN_START)
                     chain_idx_q <= idx_q;
                  if (idx_q == tx_seq_pkg::LAST_IDX && !chain_jump)
                  begin
                     state_q <= tx_seq_pkg::ST_IDLE;
                     done_q <= 1'b1;
                  end
                  else if (nxt_idx == tx_seq_pkg::FINAL_FIRST)
                  begin
                     state_q <= tx_seq_pkg::ST_FEED;
                     idx_q <= nxt_idx;
                  end
                  else
                  begin
                     idx_q <= nxt_idx;
                     cnt_q <= next_delay;
                  end
               end
               else if (tick)
                  cnt_q <= cnt_q - 16'h0001;
            tx_seq_pkg::ST_FEED:
               if (feed_left_q == '0)
               begin
                  state_q <= tx_seq_pkg::ST_RUN;
                  cnt_q <= tail_cnt;
               end
            default:
               state_q <= tx_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Modulation feed and span counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst || tx_clear)
      begin
         mod_q <= 1'b0;
         feed_left_q <= '0;
         phase_q <= '0;
         strobe_q <= 1'b0;
         finish_q <= 1'b0;
         mod_ticks_q <= '0;
         bits_q <= '0;
         fsk_q <= 1'b0;
      end
      else
      begin
         strobe_q <= 1'b0;
         finish_q <= 1'b0;
         if (seq_begin)
         begin
            bits_q <= bit_total;
            fsk_q <= fsk_mode;
         end
         if (fire && code_now == tx_seq_pkg::EV_MODULATION_BEGIN)
         begin
            mod_q <= 1'b1;
            feed_left_q <= bits_q;
            phase_q <= spb;
            strobe_q <= (bits_q != '0);
            mod_ticks_q <= '0;
         end
         else
         begin
            if (mod_q && tick)
               mod_ticks_q <= mod_ticks_q + 24'h000001;
            if (fire && code_now == tx_seq_pkg::EV_MODULATION_FINISH)
            begin
               mod_q <= 1'b0;
               finish_q <= 1'b1;
            end
            // One bit every spb ticks, five for AIS and forty for FSK
            if (tick && feed_left_q != '0)
            begin
               if (phase_q == 6'h01)
               begin
                  feed_left_q <= feed_left_q - 16'h0001;
                  phase_q <= spb;
                  strobe_q <= (feed_left_q != 16'h0001);
               end
               else
                  phase_q <= phase_q - 6'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Enable pins; levels are relative to the loaded idle state
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
         enab_q <= '0;
      else if (tx_clear || seq_begin)
         enab_q <= idle_state_q;
      else if (fire)
      begin
         unique case (code_now)
            tx_seq_pkg::EV_RADIO_ON:
               enab_q[PRF] <= ~idle_state_q[PRF];
            tx_seq_pkg::EV_RADIO_OFF:
               enab_q[PRF] <= idle_state_q[PRF];
            tx_seq_pkg::EV_TX_ON:
               enab_q[PTX] <= ~idle_state_q[PTX];
            tx_seq_pkg::EV_TX_OFF:
               enab_q[PTX] <= idle_state_q[PTX];
            tx_seq_pkg::EV_AMPLIFIER_ON:
            begin
               enab_q[PAMP] <= ~idle_state_q[PAMP];
               enab_q[PRXH:PRXL] <= ~idle_state_q[PRXH:PRXL];
            end
            tx_seq_pkg::EV_AMPLIFIER_OFF:
            begin
               enab_q[PAMP] <= idle_state_q[PAMP];
               enab_q[PRXH:PRXL] <= idle_state_q[PRXH:PRXL];
            end
            default:
               enab_q <= enab_q;
         endcase
      end
   end

   // Ramp triggers and carrier sense window
   always_ff @(posedge clk)
   begin
      if (!nrst || tx_clear)
      begin
         ramp_up_q <= 1'b0;
         ramp_down_q <= 1'b0;
         sense_q <= 1'b0;
      end
      else
      begin
         ramp_up_q <= fire && code_now == tx_seq_pkg::EV_RAMP_UP;
         ramp_down_q <= fire && code_now == tx_seq_pkg::EV_RAMP_DOWN;
         if (fire && code_now == tx_seq_pkg::EV_SENSE_WINDOW_CLOSE)
            sense_q <= 1'b0;
         else if (fire && code_now == tx_seq_pkg::EV_SENSE_WINDOW_OPEN)
            sense_q <= sense_enable && first_msg_q;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rf_enable_out = enab_q[tx_seq_pkg::PIN_RF];
   assign tx_enable_out = enab_q[tx_seq_pkg::PIN_TX];
   assign amp_enable_out = enab_q[tx_seq_pkg::PIN_AMP];
   assign rx_control_outs = enab_q[PRXH:PRXL];
   assign ramp_up_pulse = ramp_up_q;
   assign ramp_down_pulse = ramp_down_q;
   assign sense_window = sense_q;
   assign modulation_active = mod_q;
   assign bit_strobe = strobe_q;
   assign mod_finish_pulse = finish_q;
   assign tx_busy = (state_q != tx_seq_pkg::ST_IDLE);
   assign tx_done_pulse = done_q;
   assign table_ready = ready_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   wire [23:0] span_expect = 24'(bits_q * spb) + tx_seq_pkg::MOD_END_EXTRA_U;
   sequence lead_done_s;
      state_q == tx_seq_pkg::ST_LEAD && tick && cnt_last && !tx_clear;
   endsequence
   sequence run_first_s;
      state_q == tx_seq_pkg::ST_RUN && idx_q == '0
         && cnt_q == 16'(ev_delay_q[0]);
   endsequence

   lead_entry_a: assert property (start_hit && !tx_clear |=>
      state_q == tx_seq_pkg::ST_LEAD && cnt_q == tx_seq_pkg::LEAD_SAMPLES)
      else $error("lead delay not loaded");
   lead_exit_a: assert property (lead_done_s |=> run_first_s)
      else $error("first event delay not loaded after lead");
   seq_start_a: assert property (seq_begin && !tx_clear |=>
      enab_q == $past(idle_state_q) && state_q == tx_seq_pkg::ST_PENDING)
      else $error("pins not at idle state on start");
   amp_on_a: assert property (fire && !tx_clear
      && code_now == tx_seq_pkg::EV_AMPLIFIER_ON |=>
      amp_enable_out != idle_state_q[PAMP]
      && rx_control_outs == ~idle_state_q[PRXH:PRXL])
      else $error("amplifier on pin levels wrong");
   amp_off_a: assert property (fire && !tx_clear
      && code_now == tx_seq_pkg::EV_AMPLIFIER_OFF |=>
      amp_enable_out == idle_state_q[PAMP]
      && rx_control_outs == idle_state_q[PRXH:PRXL])
      else $error("amplifier off pin levels wrong");
   ev_radio_on_a: assert property (fire && !tx_clear
      && code_now == tx_seq_pkg::EV_RADIO_ON |=>
      rf_enable_out != idle_state_q[PRF])
      else $error("radio enable not asserted");
   tx_off_a: assert property (fire && !tx_clear
      && code_now == tx_seq_pkg::EV_TX_OFF |=>
      tx_enable_out == idle_state_q[PTX])
      else $error("transmit enable not negated");
   ramp_pulse_a: assert property (fire && !tx_clear
      && code_now == tx_seq_pkg::EV_RAMP_UP |=>
      ramp_up_pulse ##1 !ramp_up_pulse)
      else $error("ramp up pulse not one cycle");
   sense_open_a: assert property (fire && !tx_clear && sense_enable
      && first_msg_q && code_now == tx_seq_pkg::EV_SENSE_WINDOW_OPEN |=>
      sense_window) else $error("sense window did not open");
   mod_span_a: assert property (fire && tail_ok
      && code_now == tx_seq_pkg::EV_MODULATION_FINISH |->
      mod_ticks_q + 24'h000001 == span_expect)
      else $error("modulation span wrong");
   next_delay_a: assert property (fire && !tx_clear
      && idx_q != tx_seq_pkg::LAST_IDX
      && nxt_idx != tx_seq_pkg::FINAL_FIRST |=> cnt_q == $past(next_delay)
      && idx_q == $past(nxt_idx)) else $error("next event delay wrong");
   chain_loop_a: assert property (chain_jump && !tx_clear |=>
      idx_q == $past(chain_idx_q) + 4'h1 && !first_msg_q)
      else $error("chain did not loop to marker");
   tail_load_a: assert property (state_q == tx_seq_pkg::ST_FEED
      && feed_left_q == '0 && !tx_clear |=> state_q == tx_seq_pkg::ST_RUN
      && cnt_q == $past(tail_cnt)) else $error("final group not timed");

endmodule : tx_event_sequencer

// ===== verification/rf_front_model.sv
// Behavioural model of the external RF transmit chain and amplifier
`timescale 1ns/1ps
module rf_front_model
#(
   parameter logic [5:0] IDLE = 6'h0e
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic amp_on,
   input wire logic [2:0] rx,
   input wire logic ramp_up,
   input wire logic ramp_down,
   output logic on_air,
   output logic clash
);
   // Carrier on air only between ramp up and ramp down with amp powered
   always_ff @(posedge clk)
   begin
      if (!nrst || !amp_on || ramp_down)
         on_air <= 1'b0;
      else if (ramp_up)
         on_air <= 1'b1;
   end
   // Antenna switch still on receive while amp runs would damage the LNA
   always_ff @(posedge clk)
   begin
      if (!nrst)
         clash <= 1'b0;
      else if (amp_on && rx === IDLE[3:1])
         clash <= 1'b1;
   end
endmodule : rf_front_model

// ===== verification/tx_event_sequencer_tb.sv
// Self-checking bench for the transmit event sequencer
`timescale 1ns/1ps
module tx_event_sequencer_tb;
   localparam int DIV = 4;
   localparam logic [15:0] START = 16'h01f4;
   // Receive lines idle high, so asserting the amp drives them low
   localparam logic [5:0] IDLE = 6'h0e;
   logic clk, nrst, seq_load, seq_poke, seq_setup, tx_start, tx_clear;
   logic slot_match, fsk_mode, sense_enable, fifo_has_data;
   logic [15:0] p0, p1, sample_count, bit_total;
   logic rf, txe, amp, rup, rdn, sw, ma, bs, mfp, busy, done, rdy;
   logic on_air, clash, ma_q, amp_q;
   logic [2:0] rx, rx_on;
   int n_errors, n_checks, cyc, t_ru, t_mb, t_rd, t_mf, t_af;
   int n_sw, n_bs, n_mf, n_ru, n_air;
   logic [3:0] codes [14] = '{4'h2, 4'h1, 4'h5, 4'h6, 4'h3, 4'he, 4'h4,
      4'h7, 4'h9, 4'h8, 4'hf, 4'ha, 4'hb, 4'hc};
   logic [15:0] dl [14] = '{16'h2, 16'h3, 16'h1, 16'h7, 16'h2, 16'h1,
      16'h2, 16'h3, 16'h1, 16'ha, 16'h3, 16'h6, 16'h7, 16'h8};

   tx_event_sequencer #(.SAMPLE_DIV(DIV)) dut (.clk(clk), .nrst(nrst),
      .seq_load(seq_load), .seq_poke(seq_poke), .seq_setup(seq_setup),
      .command_param_zero(p0), .command_param_one(p1),
      .tx_start(tx_start), .tx_clear(tx_clear), .slot_match(slot_match),
      .sample_count(sample_count), .bit_total(bit_total),
      .fsk_mode(fsk_mode), .sense_enable(sense_enable),
      .fifo_has_data(fifo_has_data), .rf_enable_out(rf),
      .tx_enable_out(txe), .amp_enable_out(amp), .rx_control_outs(rx),
      .ramp_up_pulse(rup), .ramp_down_pulse(rdn), .sense_window(sw),
      .modulation_active(ma), .bit_strobe(bs), .mod_finish_pulse(mfp),
      .tx_busy(busy), .tx_done_pulse(done), .table_ready(rdy));
   rf_front_model #(.IDLE(IDLE)) rf_far (.clk(clk), .nrst(nrst),
      .amp_on(amp), .rx(rx), .ramp_up(rup), .ramp_down(rdn),
      .on_air(on_air), .clash(clash));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Event time stamps; fifo data withdrawn once the loop was taken
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      ma_q <= ma;
      amp_q <= amp;
      if (rup) t_ru <= cyc;
      if (rup) n_ru <= n_ru + 1;
      if (rup && n_ru == 1) fifo_has_data <= 1'b0;
      if (rdn) t_rd <= cyc;
      if (ma && !ma_q) t_mb <= cyc;
      if (amp && !amp_q) rx_on <= rx;
      if (!amp && amp_q) t_af <= cyc;
      if (sw) n_sw <= n_sw + 1;
      if (bs) n_bs <= n_bs + 1;
      if (on_air) n_air <= n_air + 1;
      if (mfp) t_mf <= cyc;
      if (mfp) n_mf <= n_mf + 1;
   end
   task chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1)
      begin
         $display("unexpected at %0t: %s", $time, m);
         n_errors++;
      end
   endtask : chk
   task wrap_up;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // Launch one request and check the idle pin state appears next cycle
   task launch(input logic [15:0] bits, input logic fsk, input logic more);
      @(posedge clk);
      bit_total <= bits;
      fsk_mode <= fsk;
      fifo_has_data <= more;
      tx_start <= 1'b1;
      {n_sw, n_bs, n_mf, n_ru, n_air} = '0;
      @(posedge clk);
      tx_start <= 1'b0;
      #1 chk(rx === IDLE[3:1] && busy === 1'b1, "start state");
   endtask : launch
   task wait_done;
      for (int i = 0; i < 4000 && done !== 1'b1; i++) @(posedge clk);
      chk(done === 1'b1, "no done pulse");
   endtask : wait_done
   task sc_load;
      @(posedge clk);
      seq_load <= 1'b1;
      @(posedge clk);
      seq_load <= 1'b0;
      seq_poke <= 1'b1;
      p0 <= START;
      p1 <= {10'h000, IDLE};
      for (int k = 0; k < 14; k++)
      begin
         @(posedge clk);
         p0 <= {12'h000, codes[k]};
         p1 <= dl[k];
      end
      @(posedge clk);
      seq_poke <= 1'b0;
      seq_setup <= 1'b1;
      @(posedge clk);
      seq_setup <= 1'b0;
      @(posedge clk);
      #1 chk(rdy === 1'b1, "table not ready");
   endtask : sc_load
   // Sample counter misses start, then right sample in wrong slot: request stays pending, then abort
   task sc_skip;
      sample_count <= START + 16'h0001;
      launch(16'h0004, 1'b0, 1'b0);
      repeat (12 * DIV) @(posedge clk);
      #1 chk(busy === 1'b1 && rf === 1'b0 && txe === 1'b0, "skip");
      // Right sample in the wrong slot must not start either
      slot_match <= 1'b0;
      sample_count <= START;
      repeat (12 * DIV) @(posedge clk);
      #1 chk(busy === 1'b1 && txe === 1'b0, "wrong slot");
      tx_clear <= 1'b1;
      @(posedge clk);
      tx_clear <= 1'b0;
      slot_match <= 1'b1;
      @(posedge clk);
      #1 chk(busy === 1'b0 && rx === IDLE[3:1], "clear");
   endtask : sc_skip
   task sc_single;
      launch(16'h0004, 1'b0, 1'b0);
      wait_done();
      chk(t_mf - t_mb == (4 * 5 + 46) * DIV, "ais span");
      chk(t_mb - t_ru == 3 * DIV, "relative delay");
      chk(t_mf - t_rd == 10 * DIV, "early ramp down");
      chk(t_af - t_mf == 9 * DIV, "final group");
      chk(rx_on === ~IDLE[3:1], "amp on rx");
      chk(rx === IDLE[3:1] && amp === 1'b0, "amp off rx");
      chk(n_sw == 7 * DIV, "sense window");
      chk(n_bs == 4 && n_ru == 1, "bits fed");
      chk(rf === 1'b0 && txe === 1'b0, "radio off");
      chk(n_air > 0 && clash === 1'b0, "far side");
   endtask : sc_single
   task sc_chain;
      launch(16'h0002, 1'b1, 1'b1);
      wait_done();
      chk(n_mf == 2 && n_ru == 2, "chain loop");
      chk(n_sw == 7 * DIV, "sense once");
      chk(t_mf - t_mb == (2 * 40 + 46) * DIV, "fsk span");
      chk(n_bs == 4, "chain bits");
   endtask : sc_chain

   initial
   begin
      {nrst, seq_load, seq_poke, seq_setup, tx_start, tx_clear} = '0;
      {fsk_mode, fifo_has_data, p0, p1, bit_total} = '0;
      {slot_match, sense_enable, cyc} = '0;
      {n_errors, n_checks} = '0;
      slot_match = 1'b1;
      sense_enable = 1'b1;
      sample_count = START;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1 chk({rf, txe, amp, rx, busy, rdy} === 8'h00, "reset");
      sc_load();
      sc_skip();
      sc_single();
      sc_chain();
      wrap_up();
   end
   // Whole run needs a few thousand cycles; 40000 means a hang
   initial
   begin
      #200000;
      n_errors++;
      wrap_up();
   end
endmodule : tx_event_sequencer_tb
